// [hdl/sas_sequencer.sv]
`timescale 1ns/10ps
// How it works
// - Four card slots, slot 0 the user card, slots 1 to 3 security modules.
// - Reset puts every slot, flag and output into its default state.
// - With either supply low all slots drop at once and mode reads off.
// - Shutdown request low with supplies good gives shutdown mode.
// - User card presence is tracked and reported even during shutdown.
// - Supplies good, shutdown high, every slot off: standby mode.
// - Any slot leaving the off state makes the device active.
// - User slot activates in sync type 1, sync type 2, async or manual mode.
// - Security module slots always activate asynchronously, never sync or manual.
// - Sync type 1 and type 2 activation run entirely by their own timers.
// - Async activation then checks the answer-to-reset start edge window.
// - Warm reset is offered on async activated slots only, deactivation on any activated slot.
// - Card voltage choice is latched at activation and drives the translators.
// - Edge rate choice is latched per slot and driven to the pad drivers.
// - Configuration arrives on plain control ports in place of the serial bus.
// - Fault conditions are held as sticky per-slot status for reading.
// - Sync type 1 answer bits are set up well over 1 us before sampling.
// - Sync type 1 holds reset high 68.5 us and clocks at 25 us, 50 percent.
// - Sync type 2 starts the clock only after supply settling, over 5 us.
// - Deactivation stops the clock 12 us after reset falls.
// - Deactivation removes card supply 45 us after reset falls.
// - Entering shutdown deactivates every slot that is active.
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int VCC_ON_CYC  = `SAS_CYC(`SAS_T_VCC_ON),
  parameter int ARST_CYC    = `SAS_CYC(`SAS_T_ARST),
  parameter int ATR_MIN_CYC = `SAS_CYC(`SAS_T_ATR_MIN),
  parameter int ATR_MAX_CYC = `SAS_CYC(`SAS_T_ATR_MAX),
  parameter int S1_LO_CYC   = `SAS_CYC(`SAS_T_S1_CLK_LO),
  parameter int DEAC_TL_CYC = `SAS_CYC(`SAS_T_DEAC_TOT) - `SAS_CYC(`SAS_T_DEAC_VCC),
  parameter int CLK_DIV     = `SAS_CLK_DIV
) (
  // Clocks and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cardSrcClk,
  // Supply monitors and pins, asynchronous.
  input  wire logic        vddOk,
  input  wire logic        vddiOk,
  input  wire logic        shutdownRequestN,
  input  wire logic        cardPresenceDetect,
  // Control, one-cycle requests per slot.
  input  wire logic [3:0]  actReq,
  input  wire logic [3:0]  deactReq,
  input  wire logic [3:0]  warmReq,
  input  wire logic [3:0]  faultClr,
  // Configuration levels.
  input  wire logic [1:0]  userMode,
  input  wire logic [7:0]  voltCfg,
  input  wire logic [7:0]  slewCfg,
  input  wire logic        manVcc,
  input  wire logic        manRst,
  input  wire logic        manClk,
  input  wire logic        manIoLow,
  // Card pins.
  output logic [3:0]       cardVcc,
  output logic [3:0]       cardRst,
  output logic [3:0]       cardClk,
  input  wire logic [3:0]  cardIoIn,
  output logic [3:0]       cardIoOut,
  output logic [3:0]       cardIoOe,
  output logic [7:0]       cardVolt,
  output logic [7:0]       cardSlew,
  // Status.
  output logic [3:0]       devMode,
  output logic [3:0]       slotActive,
  output logic [3:0]       slotFault,
  output logic [31:0]      atrData,
  output logic             userCardIn,
  output logic             cardInsertEvt,
  output logic             cardRemoveEvt
);

  // ****************************************
  // Derived counts
  // ****************************************
  localparam int C_S1RC = `SAS_CYC(`SAS_T_S1_RST_CLK);
  localparam int C_S1CH = `SAS_CYC(`SAS_T_S1_CLK_HI);
  localparam int C_S1CR = `SAS_CYC(`SAS_T_S1_CLK_RST);
  localparam int C_HALF = `SAS_CYC(`SAS_T_S1_HALF);
  localparam int C_S2CH = `SAS_CYC(`SAS_T_S2_CLK_HI);
  localparam int C_DCLK = `SAS_CYC(`SAS_T_DEAC_CLK);
  localparam int C_DIO  = `SAS_CYC(`SAS_T_DEAC_IO);
  localparam int C_DVCC = `SAS_CYC(`SAS_T_DEAC_VCC);

  // Timers are 21 bits wide; longer waits cannot be served. A short supply wait breaks sync type 2.
  if (ATR_MAX_CYC >= (1 << `SAS_TW) || ATR_MIN_CYC >= ATR_MAX_CYC || ARST_CYC >= (1 << `SAS_TW) ||
      VCC_ON_CYC < `SAS_CYC(`SAS_T_S2_VCC_MIN) || DEAC_TL_CYC < 1 || CLK_DIV < 1 || CLK_DIV > 256) begin : g_chk
    $error("sas_sequencer: parameter out of range");
  end

  sas_ref_s  q;
  sas_ref_s  next_q;
  sas_link_s l;
  sas_link_s next_l;

  // ****************************************
  // Reference clock sequencer
  // ****************************************
  // All four slots share one loop; slot 0 alone has the user card extras.
  always_comb begin : p_ref
    logic kill;
    logic done;
    logic fall;
    logic pwr;
    logic shutdown_request_n;
    kill = 1'b0;
    pwr  = 1'b0;
    shutdown_request_n = 1'b0;
    done = 1'b0;
    fall = 1'b0;
    next_q = q;
    // Pin synchronisers; supply monitors are combined ahead of the first stage.
    next_q.ioSy1   = cardIoIn;
    next_q.ioSy2   = q.ioSy1;
    next_q.ioOld   = q.ioSy2;
    next_q.presSy1 = cardPresenceDetect;
    next_q.presSy2 = q.presSy1;
    next_q.card_presence_detect    = q.presSy2;
    next_q.shdnSy1 = shutdownRequestN;
    next_q.shdnSy2 = q.shdnSy1;
    next_q.pwrSy1  = vddOk & vddiOk;
    next_q.pwrSy2  = q.pwrSy1;
    pwr  = q.pwrSy2;
    shutdown_request_n = ~q.shdnSy2;
    // Presence edges stay live in shutdown; only power loss stops them.
    next_q.ins = pwr & q.presSy2 & ~q.card_presence_detect;
    next_q.rem = pwr & ~q.presSy2 & q.card_presence_detect;
    for (int s = 0; s < 4; s++) begin
      next_q.tmr[s] = (q.tmr[s] == '0) ? '0 : sas_tmr_t'(q.tmr[s] - 1'b1);
      done = (q.tmr[s] == '0);
      fall = q.ioOld[s] & ~q.ioSy2[s];
      kill = (deactReq[s] | shutdown_request_n | (s == `SAS_USER_SLOT && q.rem)) &
             ~(q.st[s] inside {SAS_OFF, SAS_DRST, SAS_DCLK, SAS_DIO, SAS_DVCC});
      next_q.fault[s] = q.fault[s] & ~faultClr[s];
      if (kill) begin
        next_q.st[s]   = SAS_DRST;
        next_q.rstO[s] = 1'b0;
        next_q.tmr[s]  = sas_tmr_t'(C_DCLK);
        if (s == `SAS_USER_SLOT && q.rem) begin
          next_q.fault[s] = 1'b1;
        end
      end else begin
        unique case (q.st[s])
          SAS_OFF: begin
            // A user request without a card, or during shutdown, is ignored.
            if (actReq[s] && !shutdown_request_n && (s != `SAS_USER_SLOT || q.card_presence_detect)) begin
              next_q.volt[2*s +: 2] = voltCfg[2*s +: 2];
              next_q.slew[2*s +: 2] = slewCfg[2*s +: 2];
              if (s == `SAS_USER_SLOT) begin
                next_q.umode = sas_umode_e'(userMode);
              end
              if (s == `SAS_USER_SLOT && userMode == SAS_UM_MAN) begin
                next_q.st[s] = SAS_MAN;
              end else begin
                next_q.st[s]  = SAS_VCC;
                next_q.vcc[s] = 1'b1;
                next_q.tmr[s] = sas_tmr_t'(VCC_ON_CYC);
              end
            end
          end
          SAS_VCC: begin
            if (done) begin
              next_q.ioLow[s] = 1'b0;
              // Security module slots never look at the user mode.
              if (s != `SAS_USER_SLOT || q.umode == SAS_UM_ASYNC) begin
                next_q.st[s]   = SAS_ARST;
                next_q.aclk[s] = 1'b1;
                next_q.tmr[s]  = sas_tmr_t'(ARST_CYC);
              end else if (q.umode == SAS_UM_SYNC1) begin
                next_q.st[s]   = SAS_S1RC;
                next_q.rstO[s] = 1'b1;
                next_q.tmr[s]  = sas_tmr_t'(C_S1RC);
              end else begin
                // The supply wait is never below 5 us; the parameter check refuses less.
                next_q.st[s]   = SAS_S2CH;
                next_q.clkO[s] = 1'b1;
                next_q.tmr[s]  = sas_tmr_t'(C_S2CH);
              end
            end
          end
          SAS_ARST, SAS_WARM: begin
            if (done) begin
              next_q.st[s]   = SAS_ATR;
              next_q.rstO[s] = 1'b1;
              next_q.tmr[s]  = sas_tmr_t'(ATR_MAX_CYC);
            end
          end
          SAS_ATR: begin
            // A start edge too early, or none before the window shuts, is a fault.
            if (fall && q.tmr[s] > sas_tmr_t'(ATR_MAX_CYC - ATR_MIN_CYC)) begin
              next_q.fault[s] = 1'b1;
              next_q.st[s]    = SAS_DRST;
              next_q.rstO[s]  = 1'b0;
              next_q.tmr[s]   = sas_tmr_t'(C_DCLK);
            end else if (fall) begin
              next_q.st[s] = SAS_ON;
            end else if (done) begin
              next_q.fault[s] = 1'b1;
              next_q.st[s]    = SAS_DRST;
              next_q.rstO[s]  = 1'b0;
              next_q.tmr[s]   = sas_tmr_t'(C_DCLK);
            end
          end
          SAS_S1RC: begin
            if (done) begin
              next_q.st[s]   = SAS_S1CH;
              next_q.clkO[s] = 1'b1;
              next_q.tmr[s]  = sas_tmr_t'(C_S1CH);
            end
          end
          SAS_S1CH: begin
            if (done) begin
              next_q.st[s]   = SAS_S1CR;
              next_q.clkO[s] = 1'b0;
              next_q.tmr[s]  = sas_tmr_t'(C_S1CR);
            end
          end
          SAS_S1CR: begin
            if (done) begin
              next_q.st[s]   = SAS_S1CL;
              next_q.rstO[s] = 1'b0;
              next_q.tmr[s]  = sas_tmr_t'(S1_LO_CYC);
            end
          end
          SAS_S1CL: begin
            if (done) begin
              next_q.st[s]  = SAS_S1RUN;
              next_q.half   = '0;
              next_q.tmr[s] = sas_tmr_t'(C_HALF);
            end
          end
          SAS_S1RUN: begin
            // Equal halves give 50 percent duty; IO is sampled on each rising edge.
            if (done) begin
              next_q.clkO[s] = ~q.clkO[s];
              next_q.tmr[s]  = sas_tmr_t'(C_HALF);
              next_q.half    = q.half + 6'h01;
              if (!q.clkO[s]) begin
                next_q.atr = {q.atr[30:0], q.ioSy2[s]};
              end
              if (q.half == `SAS_S1_LAST_HALF) begin
                next_q.st[s] = SAS_ON;
              end
            end
          end
          SAS_S2CH: begin
            if (done) begin
              next_q.st[s]   = SAS_ON;
              next_q.clkO[s] = 1'b0;
            end
          end
          SAS_ON: begin
            if (warmReq[s] && q.aclk[s]) begin
              next_q.st[s]   = SAS_WARM;
              next_q.rstO[s] = 1'b0;
              next_q.tmr[s]  = sas_tmr_t'(ARST_CYC);
            end
          end
          SAS_MAN: begin
            next_q.vcc[s]   = manVcc;
            next_q.rstO[s]  = manRst;
            next_q.clkO[s]  = manClk;
            next_q.ioLow[s] = manIoLow;
          end
          SAS_DRST: begin
            if (done) begin
              next_q.st[s]   = SAS_DCLK;
              next_q.clkO[s] = 1'b0;
              next_q.aclk[s] = 1'b0;
              next_q.tmr[s]  = sas_tmr_t'(C_DIO - C_DCLK);
            end
          end
          SAS_DCLK: begin
            if (done) begin
              next_q.st[s]    = SAS_DIO;
              next_q.ioLow[s] = 1'b1;
              next_q.tmr[s]   = sas_tmr_t'(C_DVCC - C_DIO);
            end
          end
          SAS_DIO: begin
            if (done) begin
              next_q.st[s]  = SAS_DVCC;
              next_q.vcc[s] = 1'b0;
              next_q.tmr[s] = sas_tmr_t'(DEAC_TL_CYC);
            end
          end
          SAS_DVCC: begin
            if (done) begin
              next_q.st[s] = SAS_OFF;
            end
          end
        endcase
      end
      // Losing a supply drops every slot at once with no sequence.
      if (!pwr) begin
        next_q.st[s]    = SAS_OFF;
        next_q.vcc[s]   = 1'b0;
        next_q.rstO[s]  = 1'b0;
        next_q.clkO[s]  = 1'b0;
        next_q.aclk[s]  = 1'b0;
        next_q.ioLow[s] = 1'b1;
      end
    end
    // Mode reads the second sync stages and the next slot states, so it trails those stages by one cycle.
    if (!pwr) begin
      next_q.mode = SAS_M_OFF;
    end else if (shutdown_request_n) begin
      next_q.mode = SAS_M_SHUTDOWN_REQUEST_N;
    end else if (next_q.st != {4{SAS_OFF}}) begin
      next_q.mode = SAS_M_ACT;
    end else begin
      next_q.mode = SAS_M_STBY;
    end
    // Cycle count since the user slot last entered deactivation.
    next_q.cnt = (next_q.st[0] == SAS_DRST && q.st[0] != SAS_DRST) ? '0 :
                 `SAS_CNT_W'(q.cnt + 1'b1);
  end

  // Reset restores every default.
  always_ff @(posedge ref_clk) begin : p_ref_q
    if (rst) begin
      q       <= '0;
      q.st    <= {4{SAS_OFF}};
      q.ioLow <= 4'hF;
      q.umode <= SAS_UM_ASYNC;
      q.mode  <= SAS_M_OFF;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Card clock domain
  // ****************************************
  // Async card clocks run from the source clock; run levels and reset cross on two flops.
  always_comb begin : p_link
    next_l      = l;
    next_l.rst1 = rst;
    next_l.rst2 = l.rst1;
    next_l.run1 = q.aclk;
    next_l.run2 = l.run1;
    for (int s = 0; s < 4; s++) begin
      if (!l.run2[s]) begin
        next_l.div[s]  = 8'h00;
        next_l.lclk[s] = 1'b0;
      end else if (l.div[s] == 8'(CLK_DIV - 1)) begin
        next_l.div[s]  = 8'h00;
        next_l.lclk[s] = ~l.lclk[s];
      end else begin
        next_l.div[s] = l.div[s] + 8'h01;
      end
    end
    if (l.rst2) begin
      next_l.run2 = 4'h0;
      next_l.lclk = 4'h0;
      next_l.div  = '0;
    end
  end

  // The reset stages themselves take only the constant level.
  always_ff @(posedge cardSrcClk) begin : p_link_q
    l <= next_l;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Slot clocks: only one of the two sources is ever running per slot.
  assign cardVcc       = q.vcc;
  assign cardRst       = q.rstO;
  assign cardClk       = q.clkO | l.lclk;
  assign cardIoOut     = 4'h0;
  assign cardIoOe      = q.ioLow;
  assign cardVolt      = q.volt;
  assign cardSlew      = q.slew;
  assign devMode       = q.mode;
  assign slotFault     = q.fault;
  assign atrData       = q.atr;
  assign userCardIn    = q.card_presence_detect;
  assign cardInsertEvt = q.ins;
  assign cardRemoveEvt = q.rem;
  always_comb begin : p_act
    for (int s = 0; s < 4; s++) begin
      slotActive[s] = (q.st[s] == SAS_ON) || (q.st[s] == SAS_MAN);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_deac_clk_stop: assert property ($rose(q.st[0] == SAS_DCLK) |-> q.cnt == `SAS_CNT_W'(C_DCLK + 1))
    else $error("clock stop not 12 us after reset low");
  a_deac_vcc_off: assert property ($rose(q.st[0] == SAS_DVCC) |-> q.cnt == `SAS_CNT_W'(C_DVCC + 3))
    else $error("supply not removed 45 us after reset low");
  a_deac_order: assert property (q.st[0] == SAS_DIO |-> !q.rstO[0] && !q.clkO[0] && q.ioLow[0] && q.vcc[0])
    else $error("deactivation steps out of order");
  a_s1_clk_high: assert property ($rose(q.st[0] == SAS_S1CH) |-> (q.clkO[0] && q.rstO[0]) [*8])
    else $error("sync type 1 clock pulse broken");
  a_sam_async_only: assert property (((q.st[1] | q.st[2] | q.st[3]) & (SAS_S1RC | SAS_S1CH |
                                      SAS_S1CR | SAS_S1CL | SAS_S1RUN | SAS_S2CH | SAS_MAN)) == '0)
    else $error("module slot left async mode");
  a_shutdown_request_n_deact: assert property (q.pwrSy2 && $fell(q.shdnSy2) && q.st[1] == SAS_ON |=> q.st[1] == SAS_DRST)
    else $error("shutdown did not deactivate slot");
  a_power_off: assert property (!q.pwrSy2 |=> q.vcc == 4'h0 && q.mode == SAS_M_OFF)
    else $error("supply loss left a slot powered");
  a_active_mode: assert property ($past(q.pwrSy2) && $past(q.shdnSy2) && q.st[2] != SAS_OFF |->
                                  q.mode == SAS_M_ACT)
    else $error("active slot without active mode");
  a_no_card_refuse: assert property (q.st[0] == SAS_OFF && !q.card_presence_detect && q.pwrSy2 |=> q.st[0] == SAS_OFF)
    else $error("user slot started with no card");
endmodule : sas_sequencer

// [hdl/sas_regs.svh]
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

// ****************************************
// Clock rate and cycle conversion
// ****************************************
// Times are in ns; a least time rounds up to whole ref_clk cycles.
`define SAS_CLK_MHZ        125
`define SAS_CYC(ns)        ((((ns) * `SAS_CLK_MHZ) + 999) / 1000)
`define SAS_TW             21

// ****************************************
// Activation and deactivation times in ns
// ****************************************
`define SAS_T_S1_RST_CLK   28000
`define SAS_T_S1_CLK_HI    12500
`define SAS_T_S1_CLK_RST   28000
`define SAS_T_S1_CLK_LO    80000
`define SAS_T_S1_HALF      12500
`define SAS_T_S2_CLK_HI    9000
`define SAS_T_S2_VCC_MIN   5000
`define SAS_T_VCC_ON       200000
`define SAS_T_ARST         400000
`define SAS_T_ATR_MIN      40000
`define SAS_T_ATR_MAX      10000000
`define SAS_T_DEAC_CLK     12000
`define SAS_T_DEAC_IO      24000
`define SAS_T_DEAC_VCC     45000
`define SAS_T_DEAC_TOT     500000

// ****************************************
// Counts and field positions
// ****************************************
`define SAS_S1_LAST_HALF   6'h3F
`define SAS_CLK_DIV        2
`define SAS_USER_SLOT      0
`define SAS_CNT_W          17

`endif

// [hdl/sas_pkg.sv]
package sas_pkg;
  `include "sas_regs.svh"

  typedef logic [`SAS_TW-1:0] sas_tmr_t;

  // Slot sequencer states, one-hot.
  typedef enum logic [16:0] {
    SAS_OFF   = 17'h00001,
    SAS_VCC   = 17'h00002,
    SAS_ARST  = 17'h00004,
    SAS_ATR   = 17'h00008,
    SAS_S1RC  = 17'h00010,
    SAS_S1CH  = 17'h00020,
    SAS_S1CR  = 17'h00040,
    SAS_S1CL  = 17'h00080,
    SAS_S1RUN = 17'h00100,
    SAS_S2CH  = 17'h00200,
    SAS_ON    = 17'h00400,
    SAS_MAN   = 17'h00800,
    SAS_WARM  = 17'h01000,
    SAS_DRST  = 17'h02000,
    SAS_DCLK  = 17'h04000,
    SAS_DIO   = 17'h08000,
    SAS_DVCC  = 17'h10000
  } sas_slot_e;

  // User card activation modes.
  typedef enum logic [1:0] {
    SAS_UM_ASYNC = 2'h0,
    SAS_UM_SYNC1 = 2'h1,
    SAS_UM_SYNC2 = 2'h2,
    SAS_UM_MAN   = 2'h3
  } sas_umode_e;

  // Device functional modes, one-hot.
  typedef enum logic [3:0] {
    SAS_M_OFF   = 4'h1,
    SAS_M_SHUTDOWN_REQUEST_N  = 4'h2,
    SAS_M_STBY  = 4'h4,
    SAS_M_ACT   = 4'h8
  } sas_mode_e;

  typedef struct packed {
    sas_slot_e [3:0]         st;
    sas_tmr_t [3:0]          tmr;
    logic [3:0]              rstO;
    logic [3:0]              clkO;
    logic [3:0]              ioLow;
    logic [3:0]              vcc;
    logic [3:0]              aclk;
    logic [3:0]              fault;
    logic [7:0]              volt;
    logic [7:0]              slew;
    sas_umode_e              umode;
    logic [5:0]              half;
    logic [31:0]             atr;
    logic [3:0]              ioSy1;
    logic [3:0]              ioSy2;
    logic [3:0]              ioOld;
    logic                    presSy1;
    logic                    presSy2;
    logic                    card_presence_detect;
    logic                    ins;
    logic                    rem;
    logic                    shdnSy1;
    logic                    shdnSy2;
    logic                    pwrSy1;
    logic                    pwrSy2;
    sas_mode_e               mode;
    logic [`SAS_CNT_W-1:0]   cnt;
  } sas_ref_s;

  typedef struct packed {
    logic [3:0]              run1;
    logic [3:0]              run2;
    logic                    rst1;
    logic                    rst2;
    logic [3:0]              lclk;
    logic [3:0][7:0]         div;
  } sas_link_s;
endpackage : sas_pkg

// [verification/sas_card_model.sv]
`timescale 1ns/10ps
// Card side of all four slots; a muted card never answers reset.
module sas_card_model #(
  parameter int ANS_CYC = 60
) (
  input  wire logic       ref_clk,
  input  wire logic [3:0] cardVcc,
  input  wire logic [3:0] cardRst,
  input  wire logic [3:0] cardIoOe,
  input  wire logic [3:0] mute,
  output logic [3:0]      cardIoIn
);
  int         cnt[4];
  logic [3:0] pull = 4'h0;
  // The answer starts a fixed time after reset rises, well inside the window.
  always @(posedge ref_clk) begin
    for (int s = 0; s < 4; s++) begin
      cnt[s]  <= cardRst[s] ? cnt[s] + 1 : 0;
      pull[s] <= cardVcc[s] && !mute[s] && cnt[s] >= ANS_CYC;
    end
  end
  // Open drain with pull-up: the line is low if either party pulls it.
  assign cardIoIn = ~(cardIoOe | pull);
endmodule : sas_card_model

// [verification/smartcard_activation_sequencer_tb.sv]
`timescale 1ns/10ps
module smartcard_activation_sequencer_tb;
  logic ref_clk = 1'b0, rst = 1'b1, cardSrcClk = 1'b0, vddOk = 1'b1, vddiOk = 1'b1;
  logic shutdownRequestN = 1'b1, cardPresenceDetect = 1'b0, userCardIn, cardInsertEvt, cardRemoveEvt;
  logic manVcc = 1'b0, manRst = 1'b0, manClk = 1'b0, manIoLow = 1'b0;
  logic [3:0] actReq = 4'h0, deactReq = 4'h0, warmReq = 4'h0, faultClr = 4'h0, mute = 4'h0;
  logic [3:0] cardVcc, cardRst, cardClk, cardIoIn, cardIoOut, cardIoOe, devMode, slotActive, slotFault;
  logic [1:0] userMode = 2'h0, v, w;
  logic [7:0] voltCfg = 8'h00, slewCfg = 8'h00, cardVolt, cardSlew;
  logic [31:0] atrData;
  int nErrors = 0, checksDone = 0, seed = 92, k, s, clkAt, ioAt;
  // Main clock, and a link clock of unrelated phase.
  always #4 ref_clk = ~ref_clk;
  initial #5 forever #24 cardSrcClk = ~cardSrcClk;
  sas_sequencer #(.VCC_ON_CYC(700), .ARST_CYC(40), .ATR_MIN_CYC(10), .ATR_MAX_CYC(200),
    .DEAC_TL_CYC(50)) i_dut (.ref_clk, .rst, .cardSrcClk, .vddOk, .vddiOk,
    .shutdownRequestN, .cardPresenceDetect, .actReq, .deactReq, .warmReq, .faultClr, .userMode,
    .voltCfg, .slewCfg, .manVcc, .manRst, .manClk, .manIoLow, .cardVcc, .cardRst, .cardClk,
    .cardIoIn, .cardIoOut, .cardIoOe, .cardVolt, .cardSlew, .devMode, .slotActive, .slotFault,
    .atrData, .userCardIn, .cardInsertEvt, .cardRemoveEvt);
  sas_card_model i_card (.ref_clk, .cardVcc, .cardRst, .cardIoOe, .mute, .cardIoIn);
  function automatic int cyc(input int ns);
    return (ns * 125 + 999) / 1000;
  endfunction : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // Requests are one-cycle pulses launched at the falling edge.
  task automatic go(input logic [3:0] a, input logic [3:0] d);
    @(negedge ref_clk);
    actReq = a;
    deactReq = d;
    @(negedge ref_clk);
    actReq = 4'h0;
    deactReq = 4'h0;
    @(negedge ref_clk);
  endtask : go
  task automatic act(input int n);
    go(4'h1 << n, 4'h0);
    chk(cardVcc[n], 1'b1);
    for (k = 0; k < 1200 && !slotActive[n]; k++) @(negedge ref_clk);
  endtask : act
  // Times the clock stop and supply removal against the falling reset.
  task automatic deac(input int n, input logic [3:0] d);
    go(4'h0, d);
    for (k = 0; k < 20 && cardRst[n]; k++) @(negedge ref_clk);
    clkAt = 0;
    ioAt = 0;
    for (k = 0; k < 6000 && cardVcc[n]; k++) begin
      @(negedge ref_clk);
      if (cardClk[n]) clkAt = k + 1;
      if (cardIoOe[n] && ioAt == 0) ioAt = k + 1;
    end
    chk(clkAt >= cyc(10000) && clkAt <= cyc(15000), 1'b1);
    chk(ioAt > clkAt, 1'b1);
    chk(k >= cyc(45000) - 2 && k <= cyc(45000) + 6, 1'b1);
  endtask : deac
  // A slot is off only after the tail that follows supply removal.
  task automatic idle(input logic [3:0] m);
    for (k = 0; k < 7000 && (cardVcc & m) != 4'h0; k++) @(negedge ref_clk);
    repeat (60) @(negedge ref_clk);
  endtask : idle
  // The watchdog allows roughly one and a half to two times the expected run length.
  initial begin
    #600_000;
    nErrors++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    chk({devMode, cardVcc, cardIoOe}, 12'h10F);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(devMode, 4'h4);
    // Module slots with random mode, settings and a randomly mute card.
    for (s = 1; s < 4; s++) begin
      {mute[s], userMode, voltCfg, slewCfg} = $random(seed);
      v = voltCfg[2*s+:2];
      w = slewCfg[2*s+:2];
      act(s);
      voltCfg = ~voltCfg;
      slewCfg = ~slewCfg;
      chk({slotActive[s], slotFault[s]}, {!mute[s], mute[s]});
      chk({cardVolt[2*s+:2], cardSlew[2*s+:2]}, {v, w});
      if (!mute[s]) chk(devMode, 4'h8);
    end
    for (s = 1; s < 4; s++) if (!mute[s]) deac(s, 4'h1 << s);
    idle(4'hF);
    faultClr = 4'hF;
    go(4'h0, 4'h0);
    faultClr = 4'h0;
    chk({slotFault, devMode}, 8'h04);
    // Manual mode on the user slot follows the manual pin levels.
    {manVcc, manRst, manClk, manIoLow} = $random(seed);
    cardPresenceDetect = 1'b1;
    mute = 4'h0;
    userMode = 2'h3;
    for (k = 0; k < 8 && !userCardIn; k++) @(negedge ref_clk);
    chk({userCardIn, cardInsertEvt}, 2'h3);
    go(4'h1, 4'h0);
    chk({cardVcc[0], cardRst[0]}, {manVcc, manRst});
    // Supply is raised again so that it is the last step to drop.
    manVcc = 1'b1;
    go(4'h0, 4'h1);
    idle(4'h1);
    // Sync type 1: reset leads one clock pulse; the slot is cut after that pulse.
    userMode = 2'h1;
    go(4'h1, 4'h0);
    for (k = 0; k < 1000 && !cardRst[0]; k++) @(negedge ref_clk);
    for (k = 0; k < 5000 && !cardClk[0]; k++) @(negedge ref_clk);
    chk(k >= cyc(25000) && k <= cyc(32000), 1'b1);
    for (k = 0; k < 5000 && cardClk[0]; k++) @(negedge ref_clk);
    chk({cardRst[0], k >= cyc(10000) && k <= cyc(15000)}, 2'h3);
    chk(atrData, 32'h0);
    go(4'h0, 4'h1);
    idle(4'h1);
    // Sync type 2: supply settles before a single clock pulse.
    userMode = 2'h2;
    go(4'h1, 4'h0);
    for (k = 0; k < 3000 && !cardClk[0]; k++) @(negedge ref_clk);
    chk(k >= cyc(5000), 1'b1);
    for (k = 0; k < 3000 && cardClk[0]; k++) @(negedge ref_clk);
    chk(k >= cyc(7000) && k <= cyc(11000), 1'b1);
    act(1);
    chk(slotActive[1:0], 2'h3);
    // A warm reset drops reset and brings the slot back through a fresh answer.
    @(negedge ref_clk);
    warmReq = 4'h2;
    @(negedge ref_clk);
    warmReq = 4'h0;
    @(negedge ref_clk);
    chk({cardRst[1], slotActive[1]}, 2'h0);
    for (k = 0; k < 1200 && !slotActive[1]; k++) @(negedge ref_clk);
    chk(slotActive[1], 1'b1);
    // Shutdown drops every active slot with normal deactivation timing.
    shutdownRequestN = 1'b0;
    deac(1, 4'h0);
    chk({devMode, cardVcc}, 8'h20);
    cardPresenceDetect = 1'b0;
    for (k = 0; k < 8 && userCardIn; k++) @(negedge ref_clk);
    chk({userCardIn, cardRemoveEvt}, 2'h1);
    shutdownRequestN = 1'b1;
    repeat (6) @(negedge ref_clk);
    act(2);
    vddiOk = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({devMode, cardVcc}, 8'h10);
    vddiOk = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk(devMode, 4'h4);
    vddOk = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({devMode, cardVcc}, 8'h10);
    close_out();
  end
endmodule : smartcard_activation_sequencer_tb
